/* rtl/twi_map.svh */
`ifndef TWI_MAP_SVH
`define TWI_MAP_SVH

// ****************************************************************
// Link geometry
// ****************************************************************
`define TWI_BYTE_W 8
`define TWI_FIFO_DEPTH 16
`define TWI_SYNC_W_LINK 5
`define TWI_SYNC_W_CORE 2
`define TWI_RW_BIT 0
`define TWI_MSB 7
`define TWI_LAST_BIT 3'h7

// ****************************************************************
// Reset values and SDA drive level
// ****************************************************************
`define TWI_REG_RST '0
`define TWI_BYTE_RST 8'h00
`define TWI_SDA_OUT_LVL 1'b0

`endif

/* rtl/twi_pkg.sv */
package twi_pkg;
    `include "twi_map.svh"

    typedef enum logic [2:0] {
        LK_IDLE,
        LK_RX,
        LK_ACK,
        LK_TX,
        LK_TXACK,
        LK_WAIT
    } link_state_t;

    typedef struct packed {
        link_state_t state;
        logic scl_d;
        logic sda_d;
        logic [2:0] cnt;
        logic got8;
        logic [`TWI_BYTE_W-1:0] shift;
        logic first;
        logic rd_mode;
        logic sda_oe;
        logic sda_o;
        logic wr_tgl;
        logic [`TWI_BYTE_W-1:0] wr_byte;
        logic rq_tgl;
        logic rd_seen;
        logic [`TWI_BYTE_W-1:0] rd_buf;
    } link_reg_t;

    typedef struct packed {
        logic busy;
        logic wr_seen;
        logic rq_seen;
        logic pend;
        logic [`TWI_BYTE_W-1:0] pend_data;
        logic ov;
        logic [`TWI_BYTE_W-1:0] od;
        logic rd_req;
        logic rd_wait;
        logic rd_tgl;
        logic [`TWI_BYTE_W-1:0] rd_data;
    } core_reg_t;
endpackage

/* rtl/twi_sync.sv */
`timescale 1ns/1ns
module twi_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic i_clk,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_reg_t;

    sync_reg_t s;
    sync_reg_t next_s;

    // The first stage feeds only the second stage
    always_comb begin
        next_s.meta = i_d;
        next_s.q = s.meta;
    end

    always_ff @(posedge i_clk) begin
        s <= next_s;
    end

    assign o_q = s.q;
endmodule // twi_sync

/* rtl/byte_fifo.sv */
`timescale 1ns/1ns
`include "twi_map.svh"
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } fifo_reg_t;

    fifo_reg_t f;
    fifo_reg_t next_f;
    logic push;
    logic pop;

    // DEPTH must be a power of two so the pointers wrap on their own
    assign o_in_ready = (f.count != FULL_CNT);
    assign o_out_valid = (f.count != '0);
    assign o_out_data = f.mem[f.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        next_f = f;
        if (push) begin
            next_f.mem[f.wp] = i_in_data;
            next_f.wp = f.wp + 1'b1;
        end
        if (pop) begin
            next_f.rp = f.rp + 1'b1;
        end
        if (push && !pop) begin
            next_f.count = f.count + 1'b1;
        end else if (pop && !push) begin
            next_f.count = f.count - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            f <= `TWI_REG_RST;
        end else begin
            f <= next_f;
        end
    end
endmodule // byte_fifo

/* rtl/eeprom_twi_slave.sv */
// Summary of operation
// - SDA steady while SCL high; SDA change then means START or STOP.
// - Idle bus keeps SDA and SCL high; nobody pulls them low.
// - SDA changes only while SCL low; one bit per SCL pulse.
// - Unlimited bytes per transfer; only last sixteen written bytes kept; code also keeps the byte held on o_wr_data.
// - Every received byte is acknowledged on a ninth SCL pulse, unless a programming cycle runs.
// - No acknowledge while an internal programming cycle runs.
// - Acknowledge holds SDA low over the whole ninth high phase.
// - After an unacknowledged read byte SDA is released and stays high.
`timescale 1ns/1ns
`include "twi_map.svh"
module eeprom_twi_slave
    import twi_pkg::*;
#(
    parameter int FIFO_DEPTH = `TWI_FIFO_DEPTH
) (
    // Core clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Link clock, samples the two-wire bus
    input wire logic i_link_clk,
    // Two-wire bus pins
    input wire logic i_scl,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Write bytes toward the programming logic
    output logic o_wr_valid,
    output logic [`TWI_BYTE_W-1:0] o_wr_data,
    input wire logic i_wr_ready,
    input wire logic i_prog_busy,
    // Read bytes from the array
    output logic o_rd_req,
    input wire logic i_rd_valid,
    input wire logic [`TWI_BYTE_W-1:0] i_rd_data
);

    // ****************************************************************
    // Link domain
    // ****************************************************************
    link_reg_t link;
    link_reg_t next_link;
    core_reg_t core;
    core_reg_t next_core;

    logic [`TWI_SYNC_W_LINK-1:0] lsync;
    logic scl_s;
    logic sda_s;
    logic rdt_s;
    logic busy_s;
    logic link_rst_n;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // Pins, core handshake and reset all enter through two flops
    twi_sync #(
        .W(`TWI_SYNC_W_LINK)
    ) u_link_sync (
        .i_clk(i_link_clk),
        .i_d({i_scl, i_sda_i, core.rd_tgl, core.busy, i_rst_n}),
        .o_q(lsync)
    );

    assign {scl_s, sda_s, rdt_s, busy_s, link_rst_n} = lsync;
    assign scl_rise = scl_s && !link.scl_d;
    assign scl_fall = !scl_s && link.scl_d;
    assign start_ev = scl_s && link.scl_d && link.sda_d && !sda_s;
    assign stop_ev = scl_s && link.scl_d && !link.sda_d && sda_s;

    always_comb begin
        next_link = link;
        next_link.scl_d = scl_s;
        next_link.sda_d = sda_s;
        next_link.sda_o = `TWI_SDA_OUT_LVL;
        // Read byte is stable in the core while its toggle is in flight
        if (rdt_s != link.rd_seen) begin
            next_link.rd_seen = rdt_s;
            next_link.rd_buf = core.rd_data;
        end
        if (stop_ev) begin
            next_link.state = LK_IDLE;
            next_link.sda_oe = 1'b0;
        end else if (start_ev) begin
            next_link.state = LK_RX;
            next_link.cnt = '0;
            next_link.got8 = 1'b0;
            next_link.first = 1'b1;
            next_link.rd_mode = 1'b0;
            next_link.sda_oe = 1'b0;
        end else begin
            case (link.state)
                LK_IDLE: begin
                    next_link.sda_oe = 1'b0;
                end
                LK_RX: begin
                    if (scl_rise) begin
                        // Sampled in the high phase, MSB arrives first
                        next_link.shift = {link.shift[`TWI_MSB-1:0], sda_s};
                        next_link.cnt = link.cnt + 1'b1;
                        if (link.cnt == `TWI_LAST_BIT) begin
                            next_link.got8 = 1'b1;
                        end
                    end else if (scl_fall && link.got8) begin
                        next_link.got8 = 1'b0;
                        next_link.first = 1'b0;
                        if (busy_s) begin
                            // Byte is neither acknowledged nor stored
                            next_link.state = LK_WAIT;
                        end else begin
                            next_link.state = LK_ACK;
                            next_link.sda_oe = 1'b1;
                            if (link.first && link.shift[`TWI_RW_BIT]) begin
                                next_link.rd_mode = 1'b1;
                                next_link.rq_tgl = !link.rq_tgl;
                            end else if (!link.first) begin
                                next_link.wr_byte = link.shift;
                                next_link.wr_tgl = !link.wr_tgl;
                            end
                        end
                    end
                end
                LK_ACK: begin
                    // Low held until SCL falls again
                    if (scl_fall) begin
                        if (link.rd_mode) begin
                            next_link.state = LK_TX;
                            next_link.shift = link.rd_buf;
                            next_link.cnt = '0;
                            next_link.sda_oe = !link.rd_buf[`TWI_MSB];
                            next_link.rq_tgl = !link.rq_tgl;
                        end else begin
                            next_link.state = LK_RX;
                            next_link.sda_oe = 1'b0;
                        end
                    end
                end
                LK_TX: begin
                    if (scl_fall) begin
                        if (link.cnt == `TWI_LAST_BIT) begin
                            next_link.state = LK_TXACK;
                            next_link.cnt = '0;
                            next_link.sda_oe = 1'b0;
                        end else begin
                            next_link.shift = {link.shift[`TWI_MSB-1:0], 1'b0};
                            next_link.cnt = link.cnt + 1'b1;
                            next_link.sda_oe = !link.shift[`TWI_MSB-1];
                        end
                    end
                end
                LK_TXACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            next_link.state = LK_WAIT;
                        end else begin
                            next_link.got8 = 1'b1;
                        end
                    end else if (scl_fall && link.got8) begin
                        next_link.got8 = 1'b0;
                        next_link.state = LK_TX;
                        next_link.shift = link.rd_buf;
                        next_link.sda_oe = !link.rd_buf[`TWI_MSB];
                        next_link.rq_tgl = !link.rq_tgl;
                    end
                end
                LK_WAIT: begin
                    next_link.sda_oe = 1'b0;
                end
                default: begin
                    next_link.state = LK_IDLE;
                    next_link.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            link <= `TWI_REG_RST;
        end else begin
            link <= next_link;
        end
    end

    // ****************************************************************
    // Core domain
    // ****************************************************************
    logic [`TWI_SYNC_W_CORE-1:0] csync;
    logic wrt_s;
    logic rqt_s;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`TWI_BYTE_W-1:0] fifo_out_data;
    logic take;
    logic drop;

    twi_sync #(
        .W(`TWI_SYNC_W_CORE)
    ) u_core_sync (
        .i_clk(i_core_clk),
        .i_d({link.wr_tgl, link.rq_tgl}),
        .o_q(csync)
    );

    assign {wrt_s, rqt_s} = csync;

    // A full FIFO gives up its oldest byte rather than refuse the newest
    assign take = fifo_out_valid && (!core.ov || i_wr_ready);
    assign drop = core.pend && !fifo_in_ready && !take;
    assign fifo_out_ready = take || drop;

    byte_fifo #(
        .WIDTH(`TWI_BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(core.pend),
        .o_in_ready(fifo_in_ready),
        .i_in_data(core.pend_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    always_comb begin
        next_core = core;
        next_core.busy = i_prog_busy;
        next_core.rd_req = 1'b0;
        if (core.pend && fifo_in_ready) begin
            next_core.pend = 1'b0;
        end
        // Link byte stays put for many bus bits after its toggle
        if (wrt_s != core.wr_seen) begin
            next_core.wr_seen = wrt_s;
            next_core.pend = 1'b1;
            next_core.pend_data = link.wr_byte;
        end
        if (take) begin
            next_core.ov = 1'b1;
            next_core.od = fifo_out_data;
        end else if (core.ov && i_wr_ready) begin
            next_core.ov = 1'b0;
        end
        if (rqt_s != core.rq_seen) begin
            next_core.rq_seen = rqt_s;
            next_core.rd_req = 1'b1;
            next_core.rd_wait = 1'b1;
        end else if (core.rd_wait && i_rd_valid) begin
            next_core.rd_wait = 1'b0;
            next_core.rd_data = i_rd_data;
            next_core.rd_tgl = !core.rd_tgl;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            core <= `TWI_REG_RST;
        end else begin
            core <= next_core;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_sda_o = link.sda_o;
    assign o_sda_oe = link.sda_oe;
    assign o_wr_valid = core.ov;
    assign o_wr_data = core.od;
    assign o_rd_req = core.rd_req;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence byte_done_s;
        link.state == LK_RX && link.got8 && scl_fall;
    endsequence

    sequence nack_s;
        link.state == LK_TXACK && scl_rise && sda_s;
    endsequence

    sequence overflow_s;
        core.pend && !fifo_in_ready && !take;
    endsequence

    idle_release_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        link.state == LK_IDLE |=> !link.sda_oe || link.state != LK_IDLE)
    else $error("SDA driven on an idle bus");

    start_rx_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        start_ev && !stop_ev |=> link.state == LK_RX && link.cnt == '0
            && !link.sda_oe)
    else $error("START did not restart byte reception");

    stop_idle_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        stop_ev |=> link.state == LK_IDLE ##1 !link.sda_oe)
    else $error("STOP did not return the link to idle");

    sda_low_phase_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        $changed(link.sda_oe) |-> !scl_s || $past(start_ev || stop_ev))
    else $error("SDA drive changed while SCL high");

    byte_ack_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        byte_done_s |=> (link.state == LK_ACK && link.sda_oe)
            || link.state == LK_WAIT)
    else $error("Received byte not followed by acknowledge slot");

    busy_no_ack_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        byte_done_s and busy_s |=> link.state == LK_WAIT && !link.sda_oe)
    else $error("Byte acknowledged during programming cycle");

    ack_hold_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        link.state == LK_ACK && link.sda_oe && scl_s
            |=> link.sda_oe || !scl_s)
    else $error("Acknowledge released during SCL high");

    nack_release_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        nack_s and !start_ev and !stop_ev
            |=> link.state == LK_WAIT && !link.sda_oe ##1 !link.sda_oe)
    else $error("SDA not released after final read byte");

    msb_first_a: assert property (
        @(posedge i_link_clk) disable iff (!link_rst_n)
        link.state == LK_TX && scl_s
            |-> link.sda_oe == !link.shift[`TWI_MSB])
    else $error("Read bit on SDA is not the shift register MSB");

    keep_last_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        overflow_s |-> fifo_out_ready ##1 fifo_in_ready)
    else $error("Full buffer did not discard its oldest byte");

endmodule // eeprom_twi_slave

/* bench/host_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// Host processor on the two-wire bus
// ****************************************************************
module host_model (
    // Bus clock, driven push-pull by the host only
    output logic scl,
    // High while the host pulls SDA low
    output logic sda_low,
    // Wire level seen on SDA
    input wire logic sda
);
    // Quarter of an SCL period; raise it to act as a slow host
    int q = 1000;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One clock pulse; SDA sampled just after the rise and before the fall
    task automatic pulse(output logic s_rise, output logic s_fall);
        #q scl = 1'b1;
        #10 s_rise = sda;
        #(2 * q - 20) s_fall = sda;
        #10 scl = 1'b0;
        #q;
    endtask

    // Only called with the bus idle, both lines high
    task automatic start();
        sda_low = 1'b1;
        #(2 * q) scl = 1'b0;
        #q;
    endtask

    task automatic restart();
        sda_low = 1'b0;
        #q scl = 1'b1;
        #q sda_low = 1'b1;
        #q scl = 1'b0;
        #q;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #q scl = 1'b1;
        #(2 * q) sda_low = 1'b0;
        #(2 * q);
    endtask

    // ackv holds SDA at the rise and at the fall of the ninth pulse
    task automatic put_byte(input logic [7:0] b, output logic [1:0] ackv);
        logic r;
        logic f;
        for (int i = 7; i >= 0; i--) begin
            sda_low = !b[i];
            pulse(r, f);
        end
        sda_low = 1'b0;
        pulse(r, f);
        ackv = {r, f};
    endtask

    task automatic get_byte(input logic nack, output logic [7:0] b,
                            output logic steady);
        logic r;
        logic f;
        steady = 1'b1;
        sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(r, f);
            b[i] = r;
            if (r !== f) steady = 1'b0;
        end
        sda_low = !nack;
        pulse(r, f);
        sda_low = 1'b0;
    endtask
endmodule // host_model

/* bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import twi_pkg::*;
    logic i_core_clk;
    logic i_rst_n;
    logic i_link_clk;
    logic i_wr_ready;
    logic i_prog_busy;
    logic i_rd_valid = 1'b0;
    logic [7:0] i_rd_data = 8'h00;
    logic [7:0] o_wr_data;
    logic o_sda_o;
    logic o_sda_oe;
    logic o_wr_valid;
    logic o_rd_req;
    logic scl;
    logic host_low;
    wire logic sda;
    int errors = 0;
    int tests_run = 0;
    int rd_idx = 0;
    logic [7:0] got_q[$];

    // Open-drain wire with pull-up
    assign sda = (o_sda_oe ? o_sda_o : 1'b1) & !host_low;

    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    // Link clock, unrelated phase to the core clock
    initial begin
        i_link_clk = 1'b0;
        #37;
        forever begin
            #62 i_link_clk = 1'b1;
            #63 i_link_clk = 1'b0;
        end
    end

    eeprom_twi_slave #(.FIFO_DEPTH(16)) eeprom_twi_slave_i (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_link_clk(i_link_clk), .i_scl(scl), .i_sda_i(sda),
        .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
        .o_wr_valid(o_wr_valid), .o_wr_data(o_wr_data),
        .i_wr_ready(i_wr_ready), .i_prog_busy(i_prog_busy),
        .o_rd_req(o_rd_req), .i_rd_valid(i_rd_valid),
        .i_rd_data(i_rd_data));

    host_model host_model_i (.scl(scl), .sda_low(host_low), .sda(sda));

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    function automatic logic [7:0] rd_val(input int i);
        return 8'hA0 ^ 8'(i * 13);
    endfunction

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic expect_bytes(input int n);
        int k;
        k = 0;
        while (got_q.size() < n && k < 4000) begin
            @(posedge i_core_clk);
            k++;
        end
        if (got_q.size() < n) begin
            errors++;
            $display("[FAIL] byte count expected %0d seen %0d", n,
                     got_q.size());
            results();
        end
    endtask

    // Send a byte and expect an acknowledge held over the high phase
    task automatic tx(input logic [7:0] b);
        logic [1:0] a;
        host_model_i.put_byte(b, a);
        check("ack rise and fall", 8'h00, 8'(a));
    endtask

    // Collect written bytes; answer each read request one cycle later
    always @(posedge i_core_clk) begin
        if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1)
            got_q.push_back(o_wr_data);
        i_rd_valid <= 1'b0;
        if (o_rd_req === 1'b1) begin
            i_rd_valid <= 1'b1;
            i_rd_data <= rd_val(rd_idx);
            rd_idx++;
        end
    end

    always @(o_sda_oe) begin
        if (i_rst_n === 1'b1) check("sda_oe moved with scl", 8'h00, 8'(scl));
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic sc_idle();
        // Away from the core edge that may still be moving o_wr_valid
        @(negedge i_core_clk);
        check("idle pins", 8'h03,
              {2'b00, o_sda_o, o_rd_req, o_sda_oe, o_wr_valid, sda, scl});
    endtask

    task automatic sc_busy();
        logic [1:0] a;
        @(posedge i_core_clk);
        i_prog_busy <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        host_model_i.start();
        host_model_i.put_byte(8'h00, a);
        check("busy control ack", 8'h03, 8'(a));
        host_model_i.put_byte(8'h77, a);
        check("busy data ack", 8'h03, 8'(a));
        host_model_i.stop();
        @(posedge i_core_clk);
        i_prog_busy <= 1'b0;
        repeat (60) @(posedge i_core_clk);
        check("busy bytes stored", 8'h00, 8'(got_q.size()));
    endtask

    task automatic sc_write();
        host_model_i.start();
        tx(8'h00);
        tx(8'hA5);
        tx(8'h5A);
        tx(8'h01);
        tx(8'h80);
        host_model_i.stop();
        expect_bytes(4);
        check("write 0", 8'hA5, got_q.pop_front());
        check("write 1", 8'h5A, got_q.pop_front());
        check("write 2", 8'h01, got_q.pop_front());
        check("write 3", 8'h80, got_q.pop_front());
        sc_idle();
    endtask

    // Twenty bytes with the consumer stalled: the handed-over byte
    // plus the newest sixteen survive
    task automatic sc_overflow();
        @(posedge i_core_clk);
        i_wr_ready <= 1'b0;
        host_model_i.start();
        tx(8'h00);
        for (int i = 0; i < 20; i++) tx(8'h10 + 8'(i));
        host_model_i.stop();
        repeat (20) @(posedge i_core_clk);
        check("held valid", 8'h01, 8'(o_wr_valid));
        check("held byte", 8'h10, o_wr_data);
        i_wr_ready <= 1'b1;
        expect_bytes(17);
        check("kept first", 8'h10, got_q.pop_front());
        for (int k = 1; k < 17; k++) check("kept newest", 8'h13 + 8'(k), got_q.pop_front());
        repeat (100) @(posedge i_core_clk);
        check("extra bytes", 8'h00, 8'(got_q.size()));
    endtask

    // Slow host: write, repeated start, read three bytes, last refused
    task automatic sc_read();
        int base;
        logic [7:0] b;
        logic st;
        host_model_i.q = 2500;
        host_model_i.start();
        tx(8'h00);
        tx(8'h3C);
        host_model_i.restart();
        base = rd_idx;
        tx(8'h01);
        for (int k = 0; k < 3; k++) begin
            host_model_i.get_byte(k == 2, b, st);
            check("read byte", rd_val(base + k), b);
            check("read bit steady", 8'h01, 8'(st));
        end
        repeat (8) begin
            @(posedge i_link_clk);
            check("released after nack", 8'h01, {7'h00, sda});
        end
        host_model_i.stop();
        host_model_i.q = 1000;
        expect_bytes(1);
        check("write before restart", 8'h3C, got_q.pop_front());
        sc_idle();
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_wr_ready = 1'b1;
        i_prog_busy = 1'b0;
        // Long enough for three link edges as well
        repeat (5) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (20) @(posedge i_core_clk);
        sc_idle();
        sc_busy();
        sc_write();
        sc_overflow();
        sc_read();
        results();
    end
endmodule // testbench
